// >>> mapper_pkg.sv
package mapper_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the CPU bus
  // ----------------------------------------------------------------
  localparam logic [15:0] AUX_CONFIGURATION_ADDR     = 16'hd381;
  localparam logic [15:0] COLD_BOOT_FLAG_ADDR        = 16'hd383;
  localparam logic [15:0] CARTRIDGE_BANK_SELECT_ADDR = 16'hd5e0;

  // ----------------------------------------------------------------
  // Register fields and values after reset
  // ----------------------------------------------------------------
  localparam int          AUX_FLASH_WRITE_BIT   = 7;
  localparam int          AUX_SOUND_BLOCK_BIT   = 6;
  localparam int          AUX_VIDEO_LSB         = 4;
  localparam int          COLD_FLAG_BIT         = 7;
  localparam int          BANK_EXT_BIT          = 6;
  localparam int          BANK_NONE_BIT         = 7;
  localparam logic [7:0]  AUX_RESET             = 8'h00;
  localparam logic [7:0]  BANK_RESET            = 8'h00;
  localparam logic [1:0]  VIDEO_AT_D640         = 2'h1;
  localparam logic [1:0]  VIDEO_AT_D740         = 2'h2;

  // ----------------------------------------------------------------
  // Adapter port B bits that enable ROMs (low enables BASIC, game and self-test)
  // ----------------------------------------------------------------
  localparam int          ADAPTER_PORT_B_OS_BIT          = 0;
  localparam int          ADAPTER_PORT_B_BASIC_BIT       = 1;
  localparam int          ADAPTER_PORT_B_GAME_BIT        = 6;
  localparam int          ADAPTER_PORT_B_SELFTEST_BIT    = 7;

  // ----------------------------------------------------------------
  // Flash regions (19-bit byte addresses into the 512K device)
  // ----------------------------------------------------------------
  localparam logic [18:0] FLASH_BOOT_BASE       = 19'h50000;
  localparam logic [18:0] FLASH_BOOT_SELFTEST   = 19'h51000;
  localparam logic [18:0] FLASH_PBI_BASE        = 19'h58000;
  localparam logic [18:0] FLASH_BASIC_BASE      = 19'h60000;
  localparam logic [18:0] FLASH_GAME_BASE       = 19'h68000;
  localparam logic [18:0] FLASH_OS_BASE         = 19'h70000;
  localparam logic [18:0] OS_SELFTEST_OFFSET    = 19'h01000;
  localparam logic [18:0] OS_SLOT_SIZE          = 19'h04000;
  localparam logic [18:0] ROM8K_SLOT_SIZE       = 19'h02000;

  // ----------------------------------------------------------------
  // CPU address windows
  // ----------------------------------------------------------------
  localparam logic [15:0] SELFTEST_LO           = 16'h5000;
  localparam logic [15:0] SELFTEST_HI           = 16'h57ff;
  localparam logic [15:0] CART_LO               = 16'ha000;
  localparam logic [15:0] CART_HI               = 16'hbfff;
  localparam logic [15:0] OS_LOW_LO             = 16'hc000;
  localparam logic [15:0] OS_LOW_HI             = 16'hcfff;
  localparam logic [15:0] OS_HIGH_LO            = 16'hd800;
  localparam logic [7:0]  SOUND_PAGE            = 8'hd2;
  localparam logic [7:0]  SOUND_BLOCK_LO        = 8'h10;
  localparam logic [7:0]  CART_IO_PAGE          = 8'hd5;
  localparam logic [7:0]  VIDEO_PAGE_LO         = 8'hd6;
  localparam logic [7:0]  VIDEO_PAGE_HI         = 8'hd7;
  localparam logic [7:0]  VIDEO_SLOT_OFFSET     = 8'h40;

  // Where a decoded access lands.
  typedef enum logic [2:0] {
    WIN_NONE     = 3'b000,
    WIN_OS       = 3'b001,
    WIN_SELFTEST = 3'b010,
    WIN_CART     = 3'b011,
    WIN_BASIC    = 3'b100,
    WIN_GAME     = 3'b101
  } window_t;

endpackage

// >>> decode_if.sv
`timescale 1ns/1ns
// Configuration from the mapper to the window decoder, and the decode back.
interface decode_if;
  import mapper_pkg::*;
  logic [15:0] addr;
  logic        bootMapped;
  logic [1:0]  osSlot;
  logic [1:0]  basicSlot;
  logic [1:0]  gameSlot;
  logic [7:0]  bank;
  logic [7:0]  adapter_port_b;
  logic        gameJumper;
  window_t     window;
  logic [18:0] flashAddr;

  modport mapper  (output addr, bootMapped, osSlot, basicSlot, gameSlot, bank, adapter_port_b, gameJumper,
                   input window, flashAddr);
  modport decoder (input addr, bootMapped, osSlot, basicSlot, gameSlot, bank, adapter_port_b, gameJumper,
                   output window, flashAddr);
endinterface

// >>> window_decode.sv
`timescale 1ns/1ns
// Pure combinational translation of a CPU address into a flash address.
module window_decode
  import mapper_pkg::*;
(
  // Configuration in, decode out
  decode_if.decoder dec
);

  // Slot base plus offset, cut back to the flash width.
  function automatic logic [18:0] slotAddr(input logic [18:0] base, input logic [18:0] size,
                                           input logic [1:0] slot, input logic [18:0] offs);
    logic [18:0] sum;
    sum = base + size * {17'h0, slot} + offs;
    return sum;
  endfunction

  logic inRange;

  // ----------------------------------------------------------------
  // Window selection; the internal cartridge outranks BASIC and game.
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [18:0] osBase;
    logic        osWin;
    logic        intCart;
    osBase        = dec.bootMapped ? FLASH_BOOT_BASE
                  : slotAddr(FLASH_OS_BASE, OS_SLOT_SIZE, dec.osSlot, 19'h0);
    osWin         = (dec.addr >= OS_LOW_LO && dec.addr <= OS_LOW_HI) || dec.addr >= OS_HIGH_LO;
    intCart       = ~dec.bank[BANK_NONE_BIT] & ~dec.bank[BANK_EXT_BIT];
    inRange       = dec.addr >= CART_LO && dec.addr <= CART_HI;
    dec.window    = WIN_NONE;
    dec.flashAddr = 19'h0;
    if (osWin && dec.adapter_port_b[ADAPTER_PORT_B_OS_BIT])
    begin
      // Bootstrap keeps the standard OS layout: offset is the low 14 address bits.
      dec.window    = WIN_OS;
      dec.flashAddr = osBase | {5'h0, dec.addr[13:0]};
    end
    else if (dec.addr >= SELFTEST_LO && dec.addr <= SELFTEST_HI && !dec.adapter_port_b[ADAPTER_PORT_B_SELFTEST_BIT]
             && dec.adapter_port_b[ADAPTER_PORT_B_OS_BIT])
    begin
      dec.window    = WIN_SELFTEST;
      dec.flashAddr = (dec.bootMapped ? FLASH_BOOT_SELFTEST : osBase + OS_SELFTEST_OFFSET)
                    | {8'h0, dec.addr[10:0]};
    end
    else if (inRange && intCart)
    begin
      // Any of the 64 banks, so the whole device is reachable here.
      dec.window    = WIN_CART;
      dec.flashAddr = {dec.bank[5:0], dec.addr[12:0]};
    end
    else if (inRange && !dec.bootMapped && !dec.adapter_port_b[ADAPTER_PORT_B_BASIC_BIT])
    begin
      dec.window    = WIN_BASIC;
      dec.flashAddr = slotAddr(FLASH_BASIC_BASE, ROM8K_SLOT_SIZE, dec.basicSlot,
                               {6'h0, dec.addr[12:0]});
    end
    else if (inRange && !dec.bootMapped && dec.gameJumper && !dec.adapter_port_b[ADAPTER_PORT_B_GAME_BIT])
    begin
      dec.window    = WIN_GAME;
      dec.flashAddr = slotAddr(FLASH_GAME_BASE, ROM8K_SLOT_SIZE, dec.gameSlot,
                               {6'h0, dec.addr[12:0]});
    end
  end

endmodule

// >>> flash_rom_memory_mapper.sv
`timescale 1ns/1ns
module flash_rom_memory_mapper
  import mapper_pkg::*;
(
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        powerOnResetn,
  // CPU bus, one strobe per access
  input  wire logic        cpuStrobe,
  input  wire logic        cpuWrite,
  input  wire logic [15:0] cpuAddr,
  input  wire logic [7:0]  cpuWData,
  output logic [7:0]       cpuRData,
  output logic             cpuRValid,
  // Configuration from the surrounding board logic
  input  wire logic        configUnlocked,
  input  wire logic        osHandoff,
  input  wire logic [1:0]  osSlot,
  input  wire logic [1:0]  basicSlot,
  input  wire logic [1:0]  gameSlot,
  input  wire logic        internalCartAllowed,
  input  wire logic        gameJumper,
  input  wire logic        ioRamActive,
  input  wire logic [7:0]  adapterPortB,
  // Flash device
  output logic             flashCs,
  output logic             flashWe,
  output logic [18:0]      flashAddr,
  output logic [7:0]       flashWData,
  input  wire logic [7:0]  flashRData,
  // Selects for the rest of the machine
  output logic             cartIoSelect,
  output logic             extCartWindowEnable,
  output logic             leftCartSenseTrigger,
  output logic             videoBoardSelect,
  output logic             soundChipSelect,
  output logic [3:0]       auxOutputs
);
  import mapper_pkg::*;

  // ----------------------------------------------------------------
  // Timing overview
  // ----------------------------------------------------------------
  // An access is taken at the edge where cpuStrobe is high.
  // Flash strobes follow one cycle later, read data one more.
  // Strobes may come back to back: each pulse output is
  // rebuilt from the current access alone.
  // A cold flag read takes the same two cycles as a flash
  // read, so the CPU side sees a single latency.
  // The flash keeps its last mode; nothing here returns it to
  // array reads, so a stuck query state hides every window.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Software-visible configuration.
    logic [7:0]  aux;
    logic [7:0]  bank;
    logic        cold;
    logic        bootMapped;

    // Flash pins, one cycle behind the access.
    logic        flashCs;
    logic        flashWe;
    logic [18:0] flashAddr;
    logic [7:0]  flashWData;

    // Read pipeline.
    logic        readFlash;
    logic        readReg;
    logic [7:0]  regData;
    logic [7:0]  rData;
    logic        rValid;

    // Selects for the rest of the machine.
    logic        cartIo;
    logic        extWin;
    logic        trig;
    logic        video;
    logic        sound;
  } state_t;

  // Current state and its value at the next edge.
  state_t state_q;
  state_t state_d;

  // The decoder is pure logic; its answer is used in the same cycle.
  // Keeping it apart lets the window table be checked on its own.
  decode_if dec ();

  window_decode u_decode (
    .dec (dec)
  );

  // Configuration handed to the window decoder.
  // Slot selects and port B come straight from the pins.
  assign dec.addr       = cpuAddr;
  assign dec.bootMapped = state_q.bootMapped;
  assign dec.osSlot     = osSlot;
  assign dec.basicSlot  = basicSlot;
  assign dec.gameSlot   = gameSlot;
  assign dec.bank       = state_q.bank;
  assign dec.adapter_port_b      = adapterPortB;
  assign dec.gameJumper = gameJumper;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One pass builds the whole next state from the current access.
  always_comb
  begin
    logic       rd;
    logic       wr;
    logic       hit;
    logic       bankVisible;
    logic       intCartOn;
    logic       extCartOn;
    logic [7:0] page;
    logic [7:0] videoPage;

    state_d     = state_q;
    videoPage   = 8'h00;
    rd          = cpuStrobe & ~cpuWrite;
    wr          = cpuStrobe & cpuWrite;

    hit         = dec.window != WIN_NONE;
    page        = cpuAddr[15:8];
    bankVisible = internalCartAllowed;
    intCartOn   = ~state_q.bank[BANK_NONE_BIT] & ~state_q.bank[BANK_EXT_BIT];
    extCartOn   = ~state_q.bank[BANK_NONE_BIT] & state_q.bank[BANK_EXT_BIT];

    // Flash strobes last one cycle; the flash is never told about a reset,
    // so a stuck command or query state survives a reset until an F0 command write clears it.
    state_d.flashCs = 1'b0;
    state_d.flashWe = 1'b0;
    // Address and data load only on a hit and hold between hits.
    if (cpuStrobe && hit)
    begin
      state_d.flashAddr  = dec.flashAddr;
      state_d.flashWData = cpuWData;
      if (rd)
      begin
        state_d.flashCs = 1'b1;
      end
      else if (state_q.aux[AUX_FLASH_WRITE_BIT])
      begin
        // Every flash window takes writes, including the read-only ROM ranges.
        state_d.flashCs = 1'b1;
        state_d.flashWe = 1'b1;
      end
      // With writing disabled no strobe reaches the flash; address and data still load.
    end

    // Register writes land at the next edge. Only the cold flag reads
    // back, so software must keep its own copy of the others.
    if (wr && cpuAddr == AUX_CONFIGURATION_ADDR && configUnlocked)
    begin
      state_d.aux = cpuWData;
    end
    if (wr && cpuAddr == COLD_BOOT_FLAG_ADDR)
    begin
      state_d.cold = cpuWData[COLD_FLAG_BIT];
    end
    if (wr && cpuAddr == CARTRIDGE_BANK_SELECT_ADDR && bankVisible)
    begin
      state_d.bank = cpuWData;
    end

    // Handing off to the chosen OS ends the bootstrap mapping.
    // The lock that raises osHandoff lives outside this block.
    if (osHandoff)
    begin
      state_d.bootMapped = 1'b0;
    end

    // Reads: flash data arrives the cycle after the chip select.
    state_d.readFlash = rd & hit;
    state_d.readReg   = rd & ~hit & (cpuAddr == COLD_BOOT_FLAG_ADDR);
    // regData is taken a cycle early to line up with flash data.
    // cpuRValid rises only for flash hits and the cold flag.
    state_d.regData   = {state_q.cold, 7'h0};
    state_d.rValid    = state_q.readFlash | state_q.readReg;
    if (state_q.readFlash)
    begin
      // One device behind every window: in ID mode this is the ID code.
      state_d.rData = flashRData;
    end
    else if (state_q.readReg)
    begin
      state_d.rData = state_q.regData;
    end

    // Cartridge I/O covers the whole page, bank register address included.
    // A bank write therefore also reaches an external cartridge.
    state_d.cartIo = cpuStrobe & (page == CART_IO_PAGE) & ~ioRamActive;

    // Trigger and external window trail the bank register by a cycle.
    state_d.extWin = extCartOn;
    state_d.trig   = intCartOn | extCartOn;

    // External video board decoding; I/O RAM takes the page away from it.
    if (state_q.aux[AUX_VIDEO_LSB +: 2] == VIDEO_AT_D640)
    begin
      videoPage = VIDEO_PAGE_LO;
    end
    else if (state_q.aux[AUX_VIDEO_LSB +: 2] == VIDEO_AT_D740)
    begin
      videoPage = VIDEO_PAGE_HI;
    end
    else
    begin
      videoPage = 8'h00;
    end
    // Offsets below the board's slot stay with the rest of the page.
    state_d.video = cpuStrobe & (videoPage != 8'h00) & (page == videoPage)
                  & (cpuAddr[7:0] >= VIDEO_SLOT_OFFSET) & ~ioRamActive;

    // Sound chip page, with its upper part withheld when asked.
    // The first 16 bytes stay with the sound chip in every case.
    state_d.sound = cpuStrobe & (page == SOUND_PAGE)
                  & ~(state_q.aux[AUX_SOUND_BLOCK_BIT] & (cpuAddr[7:0] >= SOUND_BLOCK_LO));
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // The cold flag has its own reset so that a system reset keeps it.
  // A system reset re-maps the bootstrap image and clears every pulse
  // but leaves flash address and data alone; power-on clears it all.
  always_ff @(posedge clk)
  begin
    state_q <= state_d;
    if (!resetn)
    begin
      state_q.aux        <= AUX_RESET;
      state_q.bank       <= BANK_RESET;
      state_q.bootMapped <= 1'b1;
      state_q.flashCs    <= 1'b0;
      state_q.flashWe    <= 1'b0;
      state_q.readFlash  <= 1'b0;
      state_q.readReg    <= 1'b0;
      state_q.rValid     <= 1'b0;
      state_q.cartIo     <= 1'b0;
      state_q.extWin     <= 1'b0;
      state_q.trig       <= 1'b0;
      state_q.video      <= 1'b0;
      state_q.sound      <= 1'b0;
    end

    if (!powerOnResetn)
    begin
      state_q            <= '0;
      state_q.aux        <= AUX_RESET;
      state_q.bank       <= BANK_RESET;
      state_q.bootMapped <= 1'b1;
      state_q.cold       <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  // Nothing is decoded on the way out, so address glitches never reach a pin.
  // auxOutputs carry no meaning inside this block.
  assign cpuRData             = state_q.rData;
  assign cpuRValid            = state_q.rValid;
  assign flashCs              = state_q.flashCs;
  assign flashWe              = state_q.flashWe;
  assign flashAddr            = state_q.flashAddr;
  assign flashWData           = state_q.flashWData;
  assign cartIoSelect         = state_q.cartIo;
  assign extCartWindowEnable  = state_q.extWin;
  assign leftCartSenseTrigger = state_q.trig;
  assign videoBoardSelect     = state_q.video;
  assign soundChipSelect      = state_q.sound;
  assign auxOutputs           = state_q.aux[3:0];

endmodule

// >>> flash_mapper_props.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus-side checks on the flash mapper
// ----------------------------------------------------------------
module flash_mapper_props
  import mapper_pkg::*;
(
  // Clock and resets
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        powerOnResetn,
  // CPU bus and configuration
  input wire logic        cpuStrobe,
  input wire logic        cpuWrite,
  input wire logic [15:0] cpuAddr,
  input wire logic [7:0]  cpuWData,
  input wire logic        cpuRValid,
  input wire logic        configUnlocked,
  input wire logic        internalCartAllowed,
  input wire logic [7:0]  adapterPortB,
  // Outputs watched
  input wire logic        flashCs,
  input wire logic        flashWe,
  input wire logic        soundChipSelect,
  input wire logic        extCartWindowEnable,
  input wire logic        leftCartSenseTrigger
);
  logic [1:0] aux_q;
  wire        rst = !resetn || !powerOnResetn;
  wire        wr  = cpuStrobe && cpuWrite;

  // Shadow of the write-enable and sound-block bits, since gating depends on them.
  always_ff @(posedge clk)
    if (rst)
      aux_q <= 2'h0;
    else if (wr && cpuAddr == AUX_CONFIGURATION_ADDR && configUnlocked)
      aux_q <= cpuWData[7:6];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cs_has_cause: assert property (flashCs |-> $past(cpuStrobe))
    else $error("flash select without an access");
  a_we_is_write: assert property (flashWe |-> flashCs && $past(wr))
    else $error("flash write strobe without a write");
  a_write_blocked: assert property (wr && !aux_q[1] |=> !flashWe)
    else $error("flash write passed while disabled");
  a_os_cmd_write: assert property (wr && aux_q[1] && adapterPortB[0] &&
    cpuAddr inside {16'hf555, 16'hfaaa} |=> flashCs && flashWe)
    else $error("command write did not reach flash");
  a_os_read_answer: assert property (cpuStrobe && !cpuWrite &&
    cpuAddr[15:12] == 4'hc && adapterPortB[0] |=> flashCs ##1 cpuRValid)
    else $error("OS read not answered on time");
  a_rvalid_timing: assert property (cpuRValid |-> $past(cpuStrobe, 2) && !$past(cpuWrite, 2))
    else $error("read data without a read two cycles before");
  a_sound_hidden: assert property (aux_q[0] && cpuStrobe && cpuAddr[15:8] == SOUND_PAGE &&
    cpuAddr[7:0] >= SOUND_BLOCK_LO |=> !soundChipSelect)
    else $error("sound chip selected in blocked range");
  a_trig_ext_cart: assert property (wr && cpuAddr == CARTRIDGE_BANK_SELECT_ADDR &&
    internalCartAllowed && !cpuWData[7] |=> ##1 leftCartSenseTrigger &&
    extCartWindowEnable == $past(cpuWData[6], 2))
    else $error("sense trigger or external window wrong after bank write");
endmodule

bind flash_rom_memory_mapper flash_mapper_props i_flash_mapper_props (.*);

// >>> flash_model.sv
`timescale 1ns/1ns
// Behavioural flash device; it has no reset pin, so only an F0 command write or power loss clears its mode.
module flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] DEV_CODE = 8'ha5  // Arbitrary value.
)(
  // Flash pins
  input wire logic        clk,
  input wire logic        flashCs,
  input wire logic        flashWe,
  input wire logic [18:0] flashAddr,
  input wire logic [7:0]  flashWData,
  output logic [7:0]      flashRData
);
  logic [1:0] step_q = 2'h0;
  logic       idMode_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  wire  [7:0] rdVal = idMode_q ? (flashAddr[0] ? DEV_CODE : MFR_CODE)
                               : flashAddr[7:0] + flashAddr[18:11];

  // Idle bus shows a changing value so stale data never passes as a match.
  assign flashRData = (flashCs && !flashWe) ? rdVal : ~last_q;

  // Command decoder; survives system reset because nothing resets it.
  always @(posedge clk)
  begin
    last_q <= flashRData;
    if (flashCs && flashWe)
      if (flashWData == 8'hf0)
        idMode_q <= 1'b0;
      else if (step_q == 2'h0 && flashAddr[10:0] == 11'h555 && flashWData == 8'haa)
        step_q <= 2'h1;
      else if (step_q == 2'h1 && flashAddr[10:0] == 11'h2aa && flashWData == 8'h55)
        step_q <= 2'h2;
      else
      begin
        idMode_q <= idMode_q || (step_q == 2'h2 && flashWData == 8'h90);
        step_q <= 2'h0;
      end
  end
endmodule

// >>> tb_flash_rom_memory_mapper.sv
`timescale 1ns/1ns
module tb_flash_rom_memory_mapper;
  import mapper_pkg::*;
  localparam logic [7:0] ID_MFR = 8'h3c; // Arbitrary value.
  localparam logic [7:0] ID_DEV = 8'hc3; // Arbitrary value.
  logic        clk, resetn, powerOnResetn, cpuStrobe, cpuWrite, cpuRValid;
  logic        configUnlocked, osHandoff, internalCartAllowed, gameJumper, ioRamActive;
  logic        flashCs, flashWe, cartIoSelect, extCartWindowEnable;
  logic        leftCartSenseTrigger, videoBoardSelect, soundChipSelect;
  logic [1:0]  osSlot, basicSlot, gameSlot;
  logic [3:0]  auxOutputs;
  logic [7:0]  cpuWData, cpuRData, adapterPortB, flashWData, flashRData;
  logic [15:0] cpuAddr;
  logic [18:0] flashAddr;
  int          n_fail, n_checks;

  flash_rom_memory_mapper i_flash_rom_memory_mapper (.*);
  flash_model #(.MFR_CODE(ID_MFR), .DEV_CODE(ID_DEV)) i_flash_model (.*);

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog so a stuck run still ends with a verdict.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [18:0] exp, input logic [18:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One-cycle strobe; returns one step into the cycle after it was taken.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cpuStrobe <= 1'b1;
    cpuWrite <= w;
    cpuAddr <= a;
    cpuWData <= d;
    @(posedge clk);
    cpuStrobe <= 1'b0;
    #1;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Flash read: id selects identification codes instead of array data.
  task automatic rd(input logic [15:0] a, input logic [18:0] fa, input logic id);
    logic [7:0] e;
    e = id ? (fa[0] ? ID_DEV : ID_MFR) : fa[7:0] + fa[18:11];
    bus(1'b0, a, 8'h00);
    chk("flashCs", 1'b1, flashCs);
    chk("flashAddr", fa, flashAddr);
    step();
    chk("cpuRValid", 1'b1, cpuRValid);
    chk("cpuRData", {11'h0, e}, {11'h0, cpuRData});
  endtask

  task automatic noCs(input logic w, input logic [15:0] a);
    bus(w, a, 8'haa);
    chk("flashCs", 1'b0, flashCs);
  endtask

  task automatic rdCold(input logic [7:0] e);
    bus(1'b0, COLD_BOOT_FLAG_ADDR, 8'h00);
    step();
    chk("cpuRValid", 1'b1, cpuRValid);
    chk("coldFlag", {11'h0, e}, {11'h0, cpuRData});
  endtask

  task automatic rst(input logic pon);
    @(posedge clk);
    resetn <= 1'b0;
    powerOnResetn <= !pon;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    powerOnResetn <= 1'b1;
  endtask

  task automatic handoff();
    @(posedge clk);
    osHandoff <= 1'b1;
    @(posedge clk);
    osHandoff <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    rd(16'hc000, 19'h50000, 1'b0);
    rd(16'hd800, 19'h51800, 1'b0);
    rd(16'hffff, 19'h53fff, 1'b0);
    rd(16'h57ff, 19'h517ff, 1'b0);
  endtask

  task automatic t_flash();
    bus(1'b1, AUX_CONFIGURATION_ADDR, 8'h80);
    bus(1'b1, 16'hf555, 8'haa);
    chk("flashWe", 1'b1, flashWe);
    chk("flashAddr", 19'h53555, flashAddr);
    chk("flashWData", 8'haa, flashWData);
    bus(1'b1, 16'hfaaa, 8'h55);
    chk("flashAddr", 19'h53aaa, flashAddr);
    bus(1'b1, 16'hf555, 8'h90);
    rd(16'hc000, 19'h50000, 1'b1);
    rd(16'hd801, 19'h51801, 1'b1);
    rst(1'b0);
    rd(16'hc000, 19'h50000, 1'b1);
    bus(1'b1, AUX_CONFIGURATION_ADDR, 8'h80);
    bus(1'b1, 16'hc000, 8'hf0);
    rd(16'hc001, 19'h50001, 1'b0);
    bus(1'b1, AUX_CONFIGURATION_ADDR, 8'h00);
    noCs(1'b1, 16'hf555);
    @(posedge clk);
    configUnlocked <= 1'b0;
    bus(1'b1, AUX_CONFIGURATION_ADDR, 8'h80);
    noCs(1'b1, 16'hf555);
    configUnlocked <= 1'b1;
  endtask

  task automatic t_cold();
    rdCold(8'h80);
    bus(1'b1, COLD_BOOT_FLAG_ADDR, 8'h00);
    rst(1'b0);
    rdCold(8'h00);
    rst(1'b1);
    rdCold(8'h80);
    handoff();
    rd(16'hc000, 19'h78000, 1'b0);
    rd(16'h5000, 19'h79000, 1'b0);
    rst(1'b0);
    rd(16'hc000, 19'h50000, 1'b0);
  endtask

  task automatic t_cart();
    bus(1'b1, CARTRIDGE_BANK_SELECT_ADDR, 8'h05);
    chk("cartIoSelect", 1'b1, cartIoSelect);
    rd(16'ha000, 19'h0a000, 1'b0);
    chk("trigger", 1'b1, leftCartSenseTrigger);
    bus(1'b1, CARTRIDGE_BANK_SELECT_ADDR, 8'h3f);
    rd(16'hbfff, 19'h7ffff, 1'b0);
    bus(1'b1, CARTRIDGE_BANK_SELECT_ADDR, 8'h40);
    step();
    chk("extCart", 1'b1, extCartWindowEnable);
    chk("trigger", 1'b1, leftCartSenseTrigger);
    bus(1'b1, CARTRIDGE_BANK_SELECT_ADDR, 8'h80);
    step();
    chk("extCart", 1'b0, extCartWindowEnable);
    chk("trigger", 1'b0, leftCartSenseTrigger);
    noCs(1'b0, 16'ha000);
    internalCartAllowed <= 1'b0;
    bus(1'b1, CARTRIDGE_BANK_SELECT_ADDR, 8'h00);
    step();
    chk("trigger", 1'b0, leftCartSenseTrigger);
    internalCartAllowed <= 1'b1;
  endtask

  task automatic t_aux();
    bus(1'b1, AUX_CONFIGURATION_ADDR, 8'h1a);
    step();
    chk("auxOutputs", 4'ha, auxOutputs);
    bus(1'b0, 16'hd640, 8'h00);
    chk("video", 1'b1, videoBoardSelect);
    bus(1'b0, 16'hd740, 8'h00);
    chk("video", 1'b0, videoBoardSelect);
    ioRamActive <= 1'b1;
    bus(1'b0, 16'hd640, 8'h00);
    chk("video", 1'b0, videoBoardSelect);
    ioRamActive <= 1'b0;
    bus(1'b0, 16'hd210, 8'h00);
    chk("sound", 1'b1, soundChipSelect);
    bus(1'b1, AUX_CONFIGURATION_ADDR, 8'h60);
    bus(1'b0, 16'hd740, 8'h00);
    chk("video", 1'b1, videoBoardSelect);
    bus(1'b0, 16'hd210, 8'h00);
    chk("sound", 1'b0, soundChipSelect);
    bus(1'b0, 16'hd20f, 8'h00);
    chk("sound", 1'b1, soundChipSelect);
  endtask

  task automatic t_roms();
    bus(1'b1, CARTRIDGE_BANK_SELECT_ADDR, 8'h80);
    handoff();
    rd(16'ha000, 19'h62000, 1'b0);
    adapterPortB <= 8'h03;
    rd(16'hbfff, 19'h6ffff, 1'b0);
    gameJumper <= 1'b0;
    noCs(1'b0, 16'ha000);
    gameJumper <= 1'b1;
    adapterPortB <= 8'h43;
    noCs(1'b0, 16'ha000);
  endtask

  // Main sequence.
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    {cpuStrobe, cpuWrite, cpuAddr, cpuWData, resetn, powerOnResetn} = '0;
    {osHandoff, ioRamActive} = 2'h0;
    {configUnlocked, internalCartAllowed, gameJumper} = 3'h7;
    osSlot = 2'h2;
    basicSlot = 2'h1;
    gameSlot = 2'h3;
    adapterPortB = 8'h01;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    powerOnResetn <= 1'b1;
    t_boot();
    t_flash();
    t_cold();
    t_cart();
    t_aux();
    t_roms();
    final_report();
  end
endmodule
